// ==== shared/ebt_pkg.sv ====
package ebt_pkg;
    // bus widths and block count
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BLOCKS = 4;
    localparam int BLK_W = 2;
    // basic cycle length without waits, in system clocks
    localparam logic [3:0] BASE_CLOCKS = 4'h3;
    // most automatic waits per block
    localparam logic [2:0] MAX_AUTO_WAITS = 3'h7;
    // clocks added per external wait sample
    localparam logic [3:0] EXT_WAIT_STEP = 4'h2;
    // clocks from valid address to strobe, by strobe-delay select
    localparam logic [3:0] SETUP_LONG = 4'h2;
    localparam logic [3:0] SETUP_SHORT = 4'h1;
    // recovery lengths in system clocks
    localparam logic [3:0] RECOVER_ONE = 4'h1;
    localparam logic [3:0] RECOVER_TWO = 4'h2;
    // reset values of the loose control bits
    localparam logic STROBE_DELAY_RESET = 1'b1;
    localparam logic BUS_MODE_RESET = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [BLOCKS-1:0] CS_IDLE = 4'hf;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER
    } ebt_state_type;

    // per-block wait count field: external wait enable and automatic waits
    typedef struct packed {
        logic ext_en;
        logic [2:0] auto_waits;
    } ebt_wait_type;

    // read or write recovery field: enable and length select (0: one, 1: two clocks)
    typedef struct packed {
        logic en;
        logic two;
    } ebt_recov_type;

    // one block's entry of the chip_select_wait_regs
    typedef struct packed {
        ebt_wait_type wait_count_field;
        ebt_recov_type read_recovery_field;
        ebt_recov_type write_recovery_field;
        logic cs_recovery_field;
    } ebt_block_cfg_type;

    // access request from the internal bus
    typedef struct packed {
        logic internal;
        logic write;
        logic [BLK_W-1:0] block;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ebt_req_type;
endpackage : ebt_pkg

// ==== logic/ebt_bus_timing.sv ====
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - plain external cycle is three clocks
// - bus cycle runs on the system clock
// - internal access: hold address, float data, strobes off
// - multiplexed internal access: no latch pulse
// - zero to seven automatic waits per block
// - external wait adds clocks in pairs
// - wait field picks auto waits and external enable
// - port bit selects ready instead of wait
// - ready goes uninverted into wait logic
// - separate mode: no latch, delay still applies
// - delay select one: strobe two clocks later
// - delay select zero: strobe one clock later
// - strobe delay is global, not per block
// - latch width one or two clocks, two default
// - recovery after reads and writes, separately enabled
// - read and write recovery one or two clocks
// - chip-select recovery gives at least one dummy clock
module ebt_bus_timing (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // strap and global control bits
    input wire logic bus_mode_pin_i,
    input wire logic strobe_delay_select_i,
    input wire logic ready_pin_select_i,
    input wire ebt_pkg::ebt_block_cfg_type [ebt_pkg::BLOCKS-1:0] chip_select_wait_regs_i,
    // request from the internal bus
    input wire logic req_valid_i,
    input wire ebt_pkg::ebt_req_type req_i,
    output logic req_ready_o,
    // completion
    output logic done_o,
    output logic [ebt_pkg::DATA_W-1:0] rdata_o,
    output logic mux_mode_o,
    // external pins
    input wire logic wait_pin_port_bit_i,
    output logic [ebt_pkg::ADDR_W-1:0] addr_o,
    input wire logic [ebt_pkg::DATA_W-1:0] data_i,
    output logic [ebt_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [ebt_pkg::BLOCKS-1:0] cs_n_o
);

    // one-hot active-low chip select for a block
    function automatic logic [ebt_pkg::BLOCKS-1:0] cs_decode(input logic [ebt_pkg::BLK_W-1:0] blk);
        logic [ebt_pkg::BLOCKS-1:0] v;
        v = ebt_pkg::CS_IDLE;
        v[blk] = 1'b0;
        return v;
    endfunction : cs_decode

    // dummy clocks after a cycle; chip-select recovery gives at least one
    function automatic logic [3:0] recovery_len(input ebt_pkg::ebt_block_cfg_type c,
                                                input logic wr);
        ebt_pkg::ebt_recov_type r;
        logic [3:0] n;
        r = wr ? c.write_recovery_field : c.read_recovery_field;
        n = 4'h0;
        if (r.en) begin
            n = r.two ? ebt_pkg::RECOVER_TWO : ebt_pkg::RECOVER_ONE;
        end
        if (c.cs_recovery_field && (n == 4'h0)) begin
            n = ebt_pkg::RECOVER_ONE;
        end
        return n;
    endfunction : recovery_len

    // state
    ebt_pkg::ebt_state_type state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic strap_done_reg, strap_done_next;
    logic mux_reg, mux_next;
    logic write_reg, write_next;
    logic [ebt_pkg::DATA_W-1:0] wdata_reg, wdata_next;
    ebt_pkg::ebt_block_cfg_type cfg_reg, cfg_next;
    logic [ebt_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [ebt_pkg::DATA_W-1:0] dout_reg, dout_next;
    logic [ebt_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic oe_reg, oe_next;
    logic ale_reg, ale_next;
    logic rd_n_reg, rd_n_next;
    logic wr_n_reg, wr_n_next;
    logic [ebt_pkg::BLOCKS-1:0] cs_n_reg, cs_n_next;
    logic done_reg, done_next;
    logic ext_done_reg, ext_done_next;
    logic [4:0] len_reg, len_next;
    logic wait_req;
    logic accept;

    // ready pin is the inverse of the wait pin; low wait pin requests a wait
    assign wait_req = ready_pin_select_i ? wait_pin_port_bit_i : ~wait_pin_port_bit_i;
    assign accept = req_valid_i && (state_reg == ebt_pkg::ST_IDLE);

    // handshake and pin outputs
    assign req_ready_o = (state_reg == ebt_pkg::ST_IDLE);
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;
    assign mux_mode_o = mux_reg;
    assign addr_o = addr_reg;
    assign data_o = dout_reg;
    assign data_oe_o = oe_reg;
    assign ale_o = ale_reg;
    assign rd_n_o = rd_n_reg;
    assign wr_n_o = wr_n_reg;
    assign cs_n_o = cs_n_reg;

    // next-state logic of the bus-cycle sequencer, timed by the system clock
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        strap_done_next = 1'b1;
        mux_next = mux_reg;
        write_next = write_reg;
        wdata_next = wdata_reg;
        cfg_next = cfg_reg;
        addr_next = addr_reg;
        dout_next = dout_reg;
        rdata_next = rdata_reg;
        oe_next = oe_reg;
        ale_next = 1'b0;
        rd_n_next = rd_n_reg;
        wr_n_next = wr_n_reg;
        cs_n_next = cs_n_reg;
        done_next = 1'b0;
        ext_done_next = 1'b0;
        len_next = len_reg;
        if (!strap_done_reg) begin
            mux_next = bus_mode_pin_i;
        end
        case (state_reg)
            ebt_pkg::ST_IDLE: begin
                if (accept && req_i.internal) begin
                    // address pins keep the last external address, data floats
                    oe_next = 1'b0;
                    done_next = 1'b1;
                    len_next = 5'h00;
                end else if (accept) begin
                    write_next = req_i.write;
                    wdata_next = req_i.wdata;
                    cfg_next = chip_select_wait_regs_i[req_i.block];
                    addr_next = req_i.addr;
                    cs_n_next = cs_decode(req_i.block);
                    len_next = 5'h01;
                    // one delay setting for every block
                    cnt_next = strobe_delay_select_i ? ebt_pkg::SETUP_LONG - 4'h1
                                                     : ebt_pkg::SETUP_SHORT - 4'h1;
                    // latch pulse only in multiplexed mode
                    ale_next = mux_reg;
                    dout_next = mux_reg ? req_i.addr[ebt_pkg::DATA_W-1:0] : req_i.wdata;
                    oe_next = mux_reg || req_i.write;
                    state_next = ebt_pkg::ST_SETUP;
                end
            end
            ebt_pkg::ST_SETUP: begin
                len_next = len_reg + 5'h01;
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                    ale_next = mux_reg;
                end else begin
                    // strobe length fills the three-clock cycle plus automatic waits
                    cnt_next = ebt_pkg::BASE_CLOCKS - 4'h1 - (strobe_delay_select_i ?
                               ebt_pkg::SETUP_LONG : ebt_pkg::SETUP_SHORT)
                               + {1'b0, cfg_reg.wait_count_field.auto_waits};
                    rd_n_next = write_reg;
                    wr_n_next = ~write_reg;
                    if (mux_reg) begin
                        dout_next = wdata_reg;
                        oe_next = write_reg;
                    end
                    state_next = ebt_pkg::ST_STROBE;
                end
            end
            ebt_pkg::ST_STROBE: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                    len_next = len_reg + 5'h01;
                end else if (cfg_reg.wait_count_field.ext_en && wait_req) begin
                    // wait seen: two more clocks, then sample again
                    cnt_next = ebt_pkg::EXT_WAIT_STEP - 4'h1;
                    len_next = len_reg + 5'h01;
                end else begin
                    rd_n_next = 1'b1;
                    wr_n_next = 1'b1;
                    cs_n_next = ebt_pkg::CS_IDLE;
                    oe_next = 1'b0;
                    if (!write_reg) begin
                        rdata_next = data_i;
                    end
                    done_next = 1'b1;
                    ext_done_next = 1'b1;
                    // dummy clocks after read or write, per block
                    cnt_next = recovery_len(cfg_reg, write_reg) - 4'h1;
                    if (recovery_len(cfg_reg, write_reg) != 4'h0) begin
                        state_next = ebt_pkg::ST_RECOVER;
                    end else begin
                        state_next = ebt_pkg::ST_IDLE;
                    end
                end
            end
            ebt_pkg::ST_RECOVER: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    state_next = ebt_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = ebt_pkg::ST_IDLE;
            end
        endcase
    end

    // registers of the sequencer and pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ebt_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            strap_done_reg <= 1'b0;
            mux_reg <= ebt_pkg::BUS_MODE_RESET;
            write_reg <= 1'b0;
            wdata_reg <= ebt_pkg::DATA_RESET;
            cfg_reg <= '0;
            addr_reg <= ebt_pkg::ADDR_RESET;
            dout_reg <= ebt_pkg::DATA_RESET;
            rdata_reg <= ebt_pkg::DATA_RESET;
            oe_reg <= 1'b0;
            ale_reg <= 1'b0;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            cs_n_reg <= ebt_pkg::CS_IDLE;
            done_reg <= 1'b0;
            ext_done_reg <= 1'b0;
            len_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            strap_done_reg <= strap_done_next;
            mux_reg <= mux_next;
            write_reg <= write_next;
            wdata_reg <= wdata_next;
            cfg_reg <= cfg_next;
            addr_reg <= addr_next;
            dout_reg <= dout_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
            ale_reg <= ale_next;
            rd_n_reg <= rd_n_next;
            wr_n_reg <= wr_n_next;
            cs_n_reg <= cs_n_next;
            done_reg <= done_next;
            ext_done_reg <= ext_done_next;
            len_reg <= len_next;
        end
    end

    // strobe phases of an external cycle
    sequence s_strobe_off;
        rd_n_o && wr_n_o;
    endsequence
    sequence s_strobe_on;
        !(rd_n_o && wr_n_o);
    endsequence

    // cycle length is three clocks plus automatic waits when no external wait
    property p_cycle_len;
        @(posedge clk_i) disable iff (rst_i)
        (ext_done_reg && !cfg_reg.wait_count_field.ext_en) |->
            (len_reg == 5'h03 + {2'b00, cfg_reg.wait_count_field.auto_waits});
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("external cycle length wrong");

    // with external wait, length is three plus auto plus an even count
    property p_ext_len;
        @(posedge clk_i) disable iff (rst_i)
        (ext_done_reg && cfg_reg.wait_count_field.ext_en) |->
            (len_reg >= 5'h03 + {2'b00, cfg_reg.wait_count_field.auto_waits}) &&
            (((len_reg - 5'h03 - {2'b00, cfg_reg.wait_count_field.auto_waits}) % 2) == 0);
    endproperty
    a_ext_len: assert property (p_ext_len) else $error("external wait length not even");

    // internal access leaves the pins quiet and the address unchanged
    property p_internal;
        @(posedge clk_i) disable iff (rst_i)
        (accept && req_i.internal) |=> s_strobe_off and (!data_oe_o && !ale_o && done_o
            && $stable(addr_o) && (state_reg == ebt_pkg::ST_IDLE));
    endproperty
    a_internal: assert property (p_internal) else $error("internal access disturbed pins");

    // separate mode never drives the latch strobe
    property p_no_ale;
        @(posedge clk_i) disable iff (rst_i)
        !mux_mode_o |-> !ale_o;
    endproperty
    a_no_ale: assert property (p_no_ale) else $error("latch pulse in separate mode");

    // delay select one: strobe on the second clock after the address
    property p_delay_long;
        @(posedge clk_i) disable iff (rst_i)
        (accept && !req_i.internal && strobe_delay_select_i) |=>
            s_strobe_off ##1 s_strobe_off ##1 s_strobe_on;
    endproperty
    a_delay_long: assert property (p_delay_long) else $error("strobe not two clocks late");

    // delay select zero: strobe one clock after the address
    property p_delay_short;
        @(posedge clk_i) disable iff (rst_i)
        (accept && !req_i.internal && !strobe_delay_select_i) |=>
            s_strobe_off ##1 s_strobe_on;
    endproperty
    a_delay_short: assert property (p_delay_short) else $error("strobe not one clock late");

    // multiplexed latch pulse lasts two clocks at the default delay
    property p_ale_width;
        @(posedge clk_i) disable iff (rst_i)
        (accept && !req_i.internal && mux_mode_o && strobe_delay_select_i) |=>
            ale_o[*2] ##1 !ale_o;
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch width wrong");

    // a seen wait keeps the strobe for two more clocks
    property p_ext_hold;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == ebt_pkg::ST_STROBE && cnt_reg == 4'h0 &&
            cfg_reg.wait_count_field.ext_en && wait_req) |=> s_strobe_on ##1 s_strobe_on;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("wait not honoured");

    // ready select inverts the pin sense seen by the wait logic
    property p_ready_sense;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == ebt_pkg::ST_STROBE && cnt_reg == 4'h0 && cfg_reg.wait_count_field.ext_en
            && ready_pin_select_i && !wait_pin_port_bit_i) |=> done_o;
    endproperty
    a_ready_sense: assert property (p_ready_sense) else $error("ready not taken as release");

    // chip-select recovery keeps the engine busy one clock after the cycle
    property p_cs_recover;
        @(posedge clk_i) disable iff (rst_i)
        (ext_done_reg && cfg_reg.cs_recovery_field) |-> !req_ready_o;
    endproperty
    a_cs_recover: assert property (p_cs_recover) else $error("recovery clock missing");

    // two-clock write recovery holds off the next request for two clocks
    property p_wr_recover;
        @(posedge clk_i) disable iff (rst_i)
        (ext_done_reg && write_reg && cfg_reg.write_recovery_field.en &&
            cfg_reg.write_recovery_field.two) |-> !req_ready_o ##1 !req_ready_o ##1 req_ready_o;
    endproperty
    a_wr_recover: assert property (p_wr_recover) else $error("write recovery wrong");

endmodule : ebt_bus_timing

`default_nettype wire

// ==== test/ebt_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ebt_mem_model (
    // clock and strap copy
    input wire logic clk_i,
    input wire logic mux_i,
    // bus driven by the device
    input wire logic [ebt_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ebt_pkg::DATA_W-1:0] data_i,
    input wire logic data_oe_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [ebt_pkg::BLOCKS-1:0] cs_n_i,
    // test controls: strobe clocks to hold the wait request, pin sense
    input wire logic [3:0] hold_clocks_i,
    input wire logic ready_style_i,
    // answers to the device
    output logic [ebt_pkg::DATA_W-1:0] data_o,
    output logic wait_pin_o
);
    logic [ebt_pkg::DATA_W-1:0] mem [16];
    logic [ebt_pkg::DATA_W-1:0] latched;
    logic [ebt_pkg::DATA_W-1:0] last;
    logic [3:0] low_cnt;
    logic [3:0] idx;
    logic stb;
    logic wait_req;

    // address from the latch pulse in mux mode, else straight from the pins
    assign idx = mux_i ? latched[3:0] : addr_i[3:0];
    assign stb = !rd_n_i || !wr_n_i;
    // wait held for the first strobe clocks only, released pins never hold old data
    assign wait_req = stb && (low_cnt < hold_clocks_i);
    assign wait_pin_o = ready_style_i ? wait_req : !wait_req;
    assign data_o = (!rd_n_i && !(&cs_n_i)) ? mem[idx] : ~last;

    // latch, store, and count strobe clocks
    always_ff @(posedge clk_i) begin
        if (ale_i) latched <= data_i;
        if (!wr_n_i && data_oe_i) mem[idx] <= data_i;
        if (!rd_n_i) last <= mem[idx];
        low_cnt <= stb ? low_cnt + 4'h1 : 4'h0;
    end
endmodule : ebt_mem_model

`default_nettype wire

// ==== test/external_bus_cycle_timing_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module external_bus_cycle_timing_test;
    logic clk, rst, bus_mode, sel, rdy_sel, req_valid, req_ready, done, mux_mode;
    logic wait_pin, data_oe, ale, rd_n, wr_n;
    ebt_pkg::ebt_block_cfg_type [ebt_pkg::BLOCKS-1:0] cfg;
    ebt_pkg::ebt_req_type req;
    logic [15:0] rdata, data_in, data_out;
    logic [23:0] addr;
    logic [3:0] cs_n, hold;
    int error_cnt = 0;
    int checks_done = 0;

    ebt_bus_timing u_dut (.clk_i(clk), .rst_i(rst), .bus_mode_pin_i(bus_mode),
        .strobe_delay_select_i(sel), .ready_pin_select_i(rdy_sel),
        .chip_select_wait_regs_i(cfg), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .mux_mode_o(mux_mode),
        .wait_pin_port_bit_i(wait_pin), .addr_o(addr), .data_i(data_in), .data_o(data_out),
        .data_oe_o(data_oe), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n));

    ebt_mem_model u_mem (.clk_i(clk), .mux_i(bus_mode), .addr_i(addr), .data_i(data_out),
        .data_oe_i(data_oe), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n),
        .hold_clocks_i(hold), .ready_style_i(rdy_sel), .data_o(data_in), .wait_pin_o(wait_pin));

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // reset with the mode strap held through it
    task automatic do_reset(input logic m);
        rst = 1'b1;
        bus_mode = m;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check(mux_mode, m, "bus mode strap");
    endtask : do_reset

    task automatic set_cfg(input int b, input logic e, input logic [2:0] w,
                           input logic [1:0] rr, input logic [1:0] wrr, input logic cs);
        cfg[b] = {e, w, rr, wrr, cs};
    endtask : set_cfg

    // one request; counts cycle length, setup, latch and recovery clocks
    task automatic access(input logic intl, input logic wr, input logic [1:0] blk,
                          input logic [23:0] a, input logic [15:0] wd,
                          output int lat, output int su, output int al, output int rc);
        int n;
        logic stb;
        lat = 0;
        su = 0;
        al = 0;
        rc = 0;
        n = 0;
        stb = 1'b0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (req_ready !== 1'b1) begin
            error_cnt++;
            conclude();
        end
        req = {intl, wr, blk, a, wd};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && lat < 60) begin
            lat++;
            if (rd_n === 1'b0 || wr_n === 1'b0) stb = 1'b1;
            else if (!stb) su++;
            if (ale === 1'b1) al++;
            @(negedge clk);
        end
        lat++;
        // the done cycle counts too, so a latch pulse on an internal access is seen
        if (ale === 1'b1) al++;
        if (done !== 1'b1) begin
            error_cnt++;
            conclude();
        end
        while (req_ready !== 1'b1 && rc < 5) begin
            rc++;
            @(negedge clk);
        end
    endtask : access

    // external access with data tied to the address; e_rec below zero is not judged
    task automatic ext_op(input logic wr, input logic [1:0] blk, input logic [23:0] a,
                          input int e_lat, input int e_set, input int e_ale, input int e_rec);
        int lat, su, al, rc;
        access(1'b0, wr, blk, a, a[15:0] ^ 16'h5a5a, lat, su, al, rc);
        check(lat, e_lat, "cycle length");
        check(su, e_set, "setup clocks");
        check(al, e_ale, "latch clocks");
        check(addr, a, "address pins");
        if (e_rec >= 0) check(rc, e_rec, "recovery clocks");
        if (!wr) check(rdata, a[15:0] ^ 16'h5a5a, "read data");
    endtask : ext_op

    // internal access must leave the external pins alone
    task automatic int_op(input logic [23:0] prev);
        int lat, su, al, rc;
        access(1'b1, 1'b1, 2'h0, 24'hab_cdef, 16'hffff, lat, su, al, rc);
        check(lat, 1, "internal length");
        check(addr, prev, "address held");
        check({data_oe, rd_n, wr_n, ale, cs_n}, 8'h6f, "pins idle");
        check(al, 0, "no latch pulse");
    endtask : int_op

    task automatic t_basic;
        sel = 1'b1;
        ext_op(1'b1, 2'h0, 24'h12_3404, 4, 2, 0, -1);
        ext_op(1'b0, 2'h0, 24'h12_3404, 4, 2, 0, -1);
        int_op(24'h12_3404);
        $display("test basic finished");
    endtask : t_basic

    task automatic t_delay;
        sel = 1'b0;
        set_cfg(2, 1'b0, 3'h2, 2'b00, 2'b00, 1'b0);
        ext_op(1'b1, 2'h2, 24'h12_3408, 6, 1, 0, -1);
        ext_op(1'b0, 2'h2, 24'h12_3408, 6, 1, 0, -1);
        ext_op(1'b0, 2'h0, 24'h12_3404, 4, 1, 0, -1);
        sel = 1'b1;
        $display("test strobe delay finished");
    endtask : t_delay

    task automatic t_auto;
        for (int w = 0; w < 8; w++) begin
            set_cfg(1, 1'b0, 3'(w), 2'b00, 2'b00, 1'b0);
            ext_op(1'b0, 2'h1, 24'h12_3404, 4 + w, 2, 0, -1);
        end
        $display("test automatic waits finished");
    endtask : t_auto

    task automatic t_ext;
        hold = 4'h3;
        set_cfg(3, 1'b1, 3'h0, 2'b00, 2'b00, 1'b0);
        for (int s = 0; s < 2; s++) begin
            rdy_sel = 1'(s);
            ext_op(1'b0, 2'h3, 24'h12_3404, 8, 2, 0, -1);
        end
        set_cfg(3, 1'b0, 3'h0, 2'b00, 2'b00, 1'b0);
        ext_op(1'b0, 2'h3, 24'h12_3404, 4, 2, 0, -1);
        hold = 4'h0;
        rdy_sel = 1'b0;
        $display("test external wait finished");
    endtask : t_ext

    task automatic t_recov;
        set_cfg(0, 1'b0, 3'h0, 2'b10, 2'b00, 1'b0);
        ext_op(1'b0, 2'h0, 24'h12_3404, 4, 2, 0, 1);
        set_cfg(0, 1'b0, 3'h0, 2'b11, 2'b10, 1'b0);
        ext_op(1'b0, 2'h0, 24'h12_3404, 4, 2, 0, 2);
        ext_op(1'b1, 2'h0, 24'h12_3404, 4, 2, 0, 1);
        set_cfg(0, 1'b0, 3'h0, 2'b00, 2'b11, 1'b0);
        ext_op(1'b1, 2'h0, 24'h12_3404, 4, 2, 0, 2);
        set_cfg(0, 1'b0, 3'h0, 2'b00, 2'b00, 1'b1);
        ext_op(1'b0, 2'h0, 24'h12_3404, 4, 2, 0, 1);
        set_cfg(0, 1'b0, 3'h0, 2'b00, 2'b00, 1'b0);
        $display("test recovery finished");
    endtask : t_recov

    task automatic t_mux;
        do_reset(1'b1);
        ext_op(1'b1, 2'h0, 24'h00_5506, 4, 2, 2, -1);
        ext_op(1'b0, 2'h0, 24'h00_5506, 4, 2, 2, -1);
        sel = 1'b0;
        ext_op(1'b0, 2'h0, 24'h00_5506, 4, 1, 1, -1);
        int_op(24'h00_5506);
        $display("test multiplexed finished");
    endtask : t_mux

    // main sequence
    initial begin
        rst = 1'b1;
        bus_mode = 1'b0;
        sel = 1'b1;
        rdy_sel = 1'b0;
        hold = 4'h0;
        req_valid = 1'b0;
        req = '0;
        cfg = '0;
        do_reset(1'b0);
        t_basic();
        t_delay();
        t_auto();
        t_ext();
        t_recov();
        t_mux();
        conclude();
    end
endmodule : external_bus_cycle_timing_test

`default_nettype wire
